// ===== bench/metering_dsp_rms_temp_register_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module metering_dsp_rms_temp_register_bank_tb_top;
  import rms_bank_pkg::*;
  logic         i_clock;
  logic         i_nrst;
  apb_req_t     i_apb;
  meas_in_t     i_meas;
  apb_rsp_t     o_apb;
  cal_bank_t    o_cal;
  int           mismatches;
  int           checks;
  logic [31:0]  seed;
  logic [23:0]  cal_m [15];
  logic [31:0]  rdat;
  logic         rerr;
  logic [407:0] mv;
  //////////////////////////////////////////////////////////////////////////////
  metering_dsp_rms_temp_register_bank dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_apb(i_apb),
    .i_meas(i_meas), .o_apb(o_apb), .o_cal(o_cal));
  // free running clock
  initial i_clock = 1'b0;
  always #10 i_clock = ~i_clock;
  //////////////////////////////////////////////////////////////////////////////
  // xorshift source and expectation helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] ba(logic [14:0] ix);
    return {15'h0, ix, 2'b00};
  endfunction : ba
  function automatic logic [31:0] zpse(logic [23:0] v);
    return {4'h0, {4{v[23]}}, v};
  endfunction : zpse
  function automatic logic [23:0] fld(logic [407:0] m, int k);
    return m[407-24*k -: 24];
  endfunction : fld
  function automatic logic [31:0] sumw(logic [407:0] m);
    logic [27:0] s;
    s = 28'($signed(fld(m, 10))) + 28'($signed(fld(m, 11))) + 28'($signed(fld(m, 12)));
    return {4'h0, s};
  endfunction : sumw
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge i_clock);
    i_apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd, pstrb: st};
    @(posedge i_clock);
    i_apb.penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_apb.pready !== 1'b1 && n < 20);
    // a slave that never answers counts as a mismatch
    if (n >= 20) mismatches++;
    rdat = o_apb.prdata;
    rerr = o_apb.pslverr;
    i_apb.psel    <= 1'b0;
    i_apb.penable <= 1'b0;
  endtask : apb
  task automatic do_reset();
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (6) @(posedge i_clock);
    i_nrst <= 1'b1;
    foreach (cal_m[j]) cal_m[j] = 24'h0;
  endtask : do_reset
  // read every calibration word against the model
  task automatic chk_cal();
    for (int j = 0; j < 15; j++) begin
      apb(1'b0, ba(15'h43a9 + 15'(j)), rnd(), 4'hf);
      check(rdat, zpse(cal_m[j]));
      check({8'h0, o_cal[359-24*j -: 24]}, {8'h0, cal_m[j]});
    end
  endtask : chk_cal
  //////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
  // main sequence
  initial begin
    logic [31:0] d;
    logic [3:0]  st;
    int          j;
    seed = 32'h6cb67be3;
    mismatches = 0;
    checks = 0;
    i_nrst = 1'b0;
    i_apb = '0;
    i_meas = '0;
    mv = '0;
    for (int r = 0; r < 2; r++) begin
      do_reset();
      chk_cal();
      // random writes, full strobes for the first 15, then random byte strobes
      for (int p = 0; p < 60; p++) begin
        j = int'(rnd() % 15);
        d = rnd();
        st = (p < 15) ? 4'hf : 4'(rnd());
        apb(1'b1, ba(15'h43a9 + 15'(j)), d, st);
        check({31'h0, rerr}, 32'h0);
        for (int b = 0; b < 3; b++) if (st[b]) cal_m[j][8*b +: 8] = d[8*b +: 8];
        apb(1'b0, ba(15'h43a9 + 15'(j)), rnd(), 4'hf);
        check(rdat, zpse(cal_m[j]));
      end
      // writes to read-only words, zero to reserved words
      for (int k = 0; k < 15; k++) apb(1'b1, ba(15'h43c0 + 15'(k)), rnd(), 4'hf);
      for (int k = 0; k < 8; k++) apb(1'b1, ba(15'h43b8 + 15'(k)), 32'h0, 4'hf);
      for (int k = 0; k < 49; k++) apb(1'b1, ba(15'h43cf + 15'(k)), 32'h0, 4'hf);
      chk_cal();
      // reserved words read zero without error
      for (int k = 15'h43b8; k <= 15'h43ff; k++) begin
        if (k < 15'h43c0 || k > 15'h43ce) begin
          apb(1'b0, ba(15'(k)), rnd(), 4'hf);
          check(rdat, 32'h0);
          check({31'h0, rerr}, 32'h0);
        end
      end
      // live results, first round with most negative currents
      for (int c = 0; c < 3; c++) begin
        for (int k = 0; k < 17; k++) mv[407-24*k -: 24] = 24'(rnd());
        if (c == 0) for (int k = 10; k < 13; k++) mv[407-24*k -: 24] = 24'h800000;
        @(posedge i_clock);
        i_meas <= meas_in_t'(mv);
        for (int k = 15'h43c0; k <= 15'h43ce; k++) begin
          apb(1'b0, ba(15'(k)), rnd(), 4'hf);
          if (k == 15'h43ca) check(rdat, sumw(mv));
          else check(rdat, {8'h0, fld(mv, (k < 15'h43ca) ? k - 15'h43c0 : k - 15'h43cb + 13)});
        end
      end
      // unmapped, misaligned and high addresses refused
      apb(1'b0, 32'h00010ea0, 32'h0, 4'hf);
      check({31'h0, rerr}, 32'h1);
      apb(1'b0, 32'h00010ea5, 32'h0, 4'hf);
      check({31'h0, rerr}, 32'h1);
      apb(1'b1, 32'h00030ea4, rnd(), 4'hf);
      check({31'h0, rerr}, 32'h1);
      chk_cal();
    end
    close_out();
  end
endmodule : metering_dsp_rms_temp_register_bank_tb_top
`default_nettype wire

// ===== bench/rms_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
module rms_bank_props (
  input wire logic                    i_clock,
  input wire logic                    i_nrst,
  input wire rms_bank_pkg::apb_req_t  i_apb,
  input wire rms_bank_pkg::meas_in_t  i_meas,
  input wire rms_bank_pkg::apb_rsp_t  o_apb,
  input wire rms_bank_pkg::cal_bank_t o_cal
);
  import rms_bank_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  //////////////////////////////////////////////////////////////////////////////
  // decoded index, transfer kinds and current sum
  logic [14:0] ix;
  logic        done;
  logic        rd;
  logic        cal;
  logic        rsv;
  logic [27:0] sum28;
  assign ix    = i_apb.paddr[16:2];
  assign done  = i_apb.psel & i_apb.penable & o_apb.pready;
  assign rd    = done & ~i_apb.pwrite & ~o_apb.pslverr;
  assign cal   = (ix >= 15'h43a9) && (ix <= 15'h43b7);
  assign rsv   = ((ix >= 15'h43b8) && (ix <= 15'h43bf)) || ((ix >= 15'h43cf) && (ix <= 15'h43ff));
  assign sum28 = 28'($signed(i_meas.phase_a_instant_current)) + 28'($signed(i_meas.phase_b_instant_current))
               + 28'($signed(i_meas.phase_c_instant_current));
  // field pickers for the flat structs
  function automatic logic [23:0] mf(logic [407:0] m, int k);
    return m[407-24*k -: 24];
  endfunction : mf
  function automatic logic [23:0] cf(logic [359:0] c, int k);
    return c[359-24*k -: 24];
  endfunction : cf
  sequence s_rd(int lo, int hi);
    rd && (ix >= lo) && (ix <= hi);
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  // sign copy format
  property p_cal_fmt;
    s_rd(15'h43a9, 15'h43b7) |-> o_apb.prdata[31:28] == 4'h0 && o_apb.prdata[27:24] == {4{o_apb.prdata[23]}};
  endproperty
  a_cal_fmt: assert property (p_cal_fmt) else $error("calibration read format wrong");
  property p_rms;
    s_rd(15'h43c0, 15'h43c9) |-> o_apb.prdata == {8'h00, mf($past(i_meas), ix - 15'h43c0)};
  endproperty
  a_rms: assert property (p_rms) else $error("rms read wrong");
  property p_sum;
    s_rd(15'h43ca, 15'h43ca) |-> o_apb.prdata == {4'h0, $past(sum28, 2)};
  endproperty
  a_sum: assert property (p_sum) else $error("current sum read wrong");
  property p_temp;
    s_rd(15'h43cb, 15'h43ce) |-> o_apb.prdata == {8'h00, mf($past(i_meas), ix - 15'h43cb + 13)};
  endproperty
  a_temp: assert property (p_temp) else $error("temperature read wrong");
  property p_rsv;
    rd && rsv |-> o_apb.prdata == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read not zero");
  property p_rst;
    $rose(i_nrst) |-> o_cal == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("calibration not zero after reset");
  property p_cal_wr;
    done && i_apb.pwrite && !o_apb.pslverr && cal && i_apb.pstrb[2:0] == 3'h7
      |=> cf(o_cal, $past(ix) - 15'h43a9) == $past(i_apb.pwdata[23:0]);
  endproperty
  a_cal_wr: assert property (p_cal_wr) else $error("calibration write lost");
  property p_ro_wr;
    done && i_apb.pwrite && !cal |=> $stable(o_cal);
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("calibration changed by other write");
endmodule : rms_bank_props
bind metering_dsp_rms_temp_register_bank rms_bank_props u_props (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_apb(i_apb), .i_meas(i_meas), .o_apb(o_apb), .o_cal(o_cal));
`default_nettype wire

// ===== design/metering_dsp_rms_temp_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "rms_bank_params.svh"
module metering_dsp_rms_temp_register_bank (
  input  wire logic                   i_clock,
  input  wire logic                   i_nrst,
  input  wire rms_bank_pkg::apb_req_t i_apb,
  input  wire rms_bank_pkg::meas_in_t i_meas,
  output rms_bank_pkg::apb_rsp_t      o_apb,
  output rms_bank_pkg::cal_bank_t     o_cal
);
  import rms_bank_pkg::*;

  ////////////////////////////////////////////////////////////////
  // word formats on the bus

  // signed 24 bits, sign copied to bit 27
  function automatic logic [31:0] zpse(input logic [23:0] v);
    zpse = {4'h0, {4{v[23]}}, v};
  endfunction : zpse

  // 24 bits, eight zero bits on top
  function automatic logic [31:0] zp24(input logic [23:0] v);
    zp24 = {8'h00, v};
  endfunction : zp24

  // 28 bits, four zero bits on top
  function automatic logic [31:0] zp28(input logic [27:0] v);
    zp28 = {4'h0, v};
  endfunction : zp28

  // byte-lane merge of a write into a 24-bit word
  function automatic logic [23:0] lanes(
    input logic [23:0] old,
    input logic [31:0] wd,
    input logic [3:0]  st
  );
    lanes = old;
    for (int b = 0; b < 3; b++) begin
      if (st[b]) begin
        lanes[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction : lanes

  ////////////////////////////////////////////////////////////////
  // declarations

  cal_bank_t   cal;
  cal_bank_t   next_cal;
  apb_rsp_t    rsp;
  logic [14:0] idx;
  logic        aligned;
  logic        in_range;
  logic        addr_err;
  logic        access;
  logic        wr_fire;
  logic [31:0] rd_word;
  logic [31:0] wd;
  logic [3:0]  st;
  logic [27:0] cur_sum;

  ////////////////////////////////////////////////////////////////
  // address decode
  assign idx      = i_apb.paddr[`IX_MSB:`IX_LSB];
  assign aligned  = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr[31:17] == 15'h0000);
  assign in_range = (idx >= `IX_FIRST) && (idx <= `IX_LAST);
  assign addr_err = !(aligned && in_range);
  assign wd       = i_apb.pwdata;
  assign st       = i_apb.pstrb;

  // access phase and completing write
  assign access  = i_apb.psel && i_apb.penable;
  assign wr_fire = access && rsp.pready && i_apb.pwrite && !addr_err;

  ////////////////////////////////////////////////////////////////
  // current sum, registered in its own block
  phase_current_summer u_summer (
    .i_clock   (i_clock),
    .i_nrst    (i_nrst),
    .i_phase_a (i_meas.phase_a_instant_current),
    .i_phase_b (i_meas.phase_b_instant_current),
    .i_phase_c (i_meas.phase_c_instant_current),
    .o_sum     (cur_sum)
  );

  ////////////////////////////////////////////////////////////////
  // write decode for the calibration words
  always_comb begin
    next_cal = cal;
    if (wr_fire) begin
      if (idx == `IX_FIRMS_OFS_A) begin
        next_cal.phase_a_fund_current_rms_offset = lanes(cal.phase_a_fund_current_rms_offset, wd, st);
      end else if (idx == `IX_FIRMS_OFS_B) begin
        next_cal.phase_b_fund_current_rms_offset = lanes(cal.phase_b_fund_current_rms_offset, wd, st);
      end else if (idx == `IX_FIRMS_OFS_C) begin
        next_cal.phase_c_fund_current_rms_offset = lanes(cal.phase_c_fund_current_rms_offset, wd, st);
      end else if (idx == `IX_FVRMS_OFS_A) begin
        next_cal.phase_a_fund_voltage_rms_offset = lanes(cal.phase_a_fund_voltage_rms_offset, wd, st);
      end else if (idx == `IX_FVRMS_OFS_B) begin
        next_cal.phase_b_fund_voltage_rms_offset = lanes(cal.phase_b_fund_voltage_rms_offset, wd, st);
      end else if (idx == `IX_FVRMS_OFS_C) begin
        next_cal.phase_c_fund_voltage_rms_offset = lanes(cal.phase_c_fund_voltage_rms_offset, wd, st);
      end else if (idx == `IX_TEMP_COEF) begin
        next_cal.shunt_temp_coefficient = lanes(cal.shunt_temp_coefficient, wd, st);
      end else if (idx == `IX_CAL_AMB_A) begin
        next_cal.phase_a_cal_ambient_temp = lanes(cal.phase_a_cal_ambient_temp, wd, st);
      end else if (idx == `IX_CAL_AMB_B) begin
        next_cal.phase_b_cal_ambient_temp = lanes(cal.phase_b_cal_ambient_temp, wd, st);
      end else if (idx == `IX_CAL_AMB_C) begin
        next_cal.phase_c_cal_ambient_temp = lanes(cal.phase_c_cal_ambient_temp, wd, st);
      end else if (idx == `IX_CAL_AMB_N) begin
        next_cal.neutral_cal_ambient_temp = lanes(cal.neutral_cal_ambient_temp, wd, st);
      end else if (idx == `IX_TEMP_GAIN_A) begin
        next_cal.phase_a_temp_gain_adjust = lanes(cal.phase_a_temp_gain_adjust, wd, st);
      end else if (idx == `IX_TEMP_GAIN_B) begin
        next_cal.phase_b_temp_gain_adjust = lanes(cal.phase_b_temp_gain_adjust, wd, st);
      end else if (idx == `IX_TEMP_GAIN_C) begin
        next_cal.phase_c_temp_gain_adjust = lanes(cal.phase_c_temp_gain_adjust, wd, st);
      end else if (idx == `IX_TEMP_GAIN_N) begin
        next_cal.neutral_temp_gain_adjust = lanes(cal.neutral_temp_gain_adjust, wd, st);
      end
      // reserved and read-only words keep nothing
    end
  end

  // calibration storage, zero from reset
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cal <= '{default: `CAL_RESET};
    end else begin
      cal <= next_cal;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read mux with per-word bus format
  always_comb begin
    rd_word = `RESERVED_WORD;
    if (addr_err) begin
      rd_word = `RESERVED_WORD;
    end else if (idx == `IX_FIRMS_OFS_A) begin
      rd_word = zpse(cal.phase_a_fund_current_rms_offset);
    end else if (idx == `IX_FIRMS_OFS_B) begin
      rd_word = zpse(cal.phase_b_fund_current_rms_offset);
    end else if (idx == `IX_FIRMS_OFS_C) begin
      rd_word = zpse(cal.phase_c_fund_current_rms_offset);
    end else if (idx == `IX_FVRMS_OFS_A) begin
      rd_word = zpse(cal.phase_a_fund_voltage_rms_offset);
    end else if (idx == `IX_FVRMS_OFS_B) begin
      rd_word = zpse(cal.phase_b_fund_voltage_rms_offset);
    end else if (idx == `IX_FVRMS_OFS_C) begin
      rd_word = zpse(cal.phase_c_fund_voltage_rms_offset);
    end else if (idx == `IX_TEMP_COEF) begin
      rd_word = zpse(cal.shunt_temp_coefficient);
    end else if (idx == `IX_CAL_AMB_A) begin
      rd_word = zpse(cal.phase_a_cal_ambient_temp);
    end else if (idx == `IX_CAL_AMB_B) begin
      rd_word = zpse(cal.phase_b_cal_ambient_temp);
    end else if (idx == `IX_CAL_AMB_C) begin
      rd_word = zpse(cal.phase_c_cal_ambient_temp);
    end else if (idx == `IX_CAL_AMB_N) begin
      rd_word = zpse(cal.neutral_cal_ambient_temp);
    end else if (idx == `IX_TEMP_GAIN_A) begin
      rd_word = zpse(cal.phase_a_temp_gain_adjust);
    end else if (idx == `IX_TEMP_GAIN_B) begin
      rd_word = zpse(cal.phase_b_temp_gain_adjust);
    end else if (idx == `IX_TEMP_GAIN_C) begin
      rd_word = zpse(cal.phase_c_temp_gain_adjust);
    end else if (idx == `IX_TEMP_GAIN_N) begin
      rd_word = zpse(cal.neutral_temp_gain_adjust);
    end else if (idx >= `IX_RSV1_LO && idx <= `IX_RSV1_HI) begin
      rd_word = `RESERVED_WORD;
    end else if (idx == `IX_IRMS_A) begin
      rd_word = zp24(i_meas.phase_a_current_rms_result);
    end else if (idx == `IX_VRMS_A) begin
      rd_word = zp24(i_meas.phase_a_voltage_rms_result);
    end else if (idx == `IX_V2RMS_A) begin
      rd_word = zp24(i_meas.phase_a_second_voltage_rms_result);
    end else if (idx == `IX_IRMS_B) begin
      rd_word = zp24(i_meas.phase_b_current_rms_result);
    end else if (idx == `IX_VRMS_B) begin
      rd_word = zp24(i_meas.phase_b_voltage_rms_result);
    end else if (idx == `IX_V2RMS_B) begin
      rd_word = zp24(i_meas.phase_b_second_voltage_rms_result);
    end else if (idx == `IX_IRMS_C) begin
      rd_word = zp24(i_meas.phase_c_current_rms_result);
    end else if (idx == `IX_VRMS_C) begin
      rd_word = zp24(i_meas.phase_c_voltage_rms_result);
    end else if (idx == `IX_V2RMS_C) begin
      rd_word = zp24(i_meas.phase_c_second_voltage_rms_result);
    end else if (idx == `IX_IRMS_N) begin
      rd_word = zp24(i_meas.neutral_current_rms_result);
    end else if (idx == `IX_CUR_SUM) begin
      rd_word = zp28(cur_sum);
    end else if (idx == `IX_SENS_TEMP_A) begin
      rd_word = zp24(i_meas.phase_a_sensor_temperature);
    end else if (idx == `IX_SENS_TEMP_B) begin
      rd_word = zp24(i_meas.phase_b_sensor_temperature);
    end else if (idx == `IX_SENS_TEMP_C) begin
      rd_word = zp24(i_meas.phase_c_sensor_temperature);
    end else if (idx == `IX_SENS_TEMP_N) begin
      rd_word = zp24(i_meas.neutral_sensor_temperature);
    end else if (idx >= `IX_RSV2_LO && idx <= `IX_RSV2_HI) begin
      rd_word = `RESERVED_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb answer: one wait state, then pready for one cycle
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp <= '0;
    end else if (access && !rsp.pready) begin
      rsp.pready  <= 1'b1;
      rsp.pslverr <= addr_err;
      rsp.prdata  <= i_apb.pwrite ? `RESERVED_WORD : rd_word;
    end else begin
      rsp.pready  <= 1'b0;
      rsp.pslverr <= 1'b0;
      rsp.prdata  <= rsp.prdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs straight from the flops
  assign o_apb = rsp;
  assign o_cal = cal;

endmodule : metering_dsp_rms_temp_register_bank
`default_nettype wire

// ===== design/phase_current_summer.sv
`timescale 1ns/1ps
`default_nettype none
module phase_current_summer (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic [23:0] i_phase_a,
  input  wire logic [23:0] i_phase_b,
  input  wire logic [23:0] i_phase_c,
  output logic      [27:0] o_sum
);

  ////////////////////////////////////////////////////////////////
  // widen each signed sample before adding
  function automatic logic [27:0] widen(input logic [23:0] v);
    widen = {{4{v[23]}}, v};
  endfunction : widen

  logic [27:0] next_sum;

  assign next_sum = widen(i_phase_a) + widen(i_phase_b) + widen(i_phase_c);

  // registered sum, one cycle behind the samples
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sum <= 28'h0000000;
    end else begin
      o_sum <= next_sum;
    end
  end

endmodule : phase_current_summer
`default_nettype wire

// ===== design/rms_bank_params.svh
// Contract
// - signed 24-bit calibration words read back as 32 bits: sign copied up to bit 27, top four bits zero.
// - 24-bit result words read back as 32 bits with the top eight bits zero and no sign copy.
// - the 28-bit result word reads back as 32 bits with the top four bits zero.
// - a read-only signed 28-bit word holds the sum of the three phase instantaneous currents.
// - the six fundamental current and voltage rms offsets are read-write signed 24-bit, reset to zero.
// - the ten rms results are read-only 24-bit values with no reset value of their own.
// - the shunt temperature coefficient is read-write signed 24-bit, reset to zero.
// - the four ambient temperatures at calibration are read-write signed 24-bit, reset to zero.
// - the four temperature gain adjusts are read-write signed 24-bit, reset to zero.
// - the four sensor temperatures are read-only 24-bit words in zero-pad form.
`ifndef RMS_BANK_PARAMS_SVH
`define RMS_BANK_PARAMS_SVH
// register indices; byte address is four times the index
`define IX_FIRST          15'h43a9
`define IX_LAST           15'h43ff
`define IX_FIRMS_OFS_A    15'h43a9
`define IX_FIRMS_OFS_B    15'h43aa
`define IX_FIRMS_OFS_C    15'h43ab
`define IX_FVRMS_OFS_A    15'h43ac
`define IX_FVRMS_OFS_B    15'h43ad
`define IX_FVRMS_OFS_C    15'h43ae
`define IX_TEMP_COEF      15'h43af
`define IX_CAL_AMB_A      15'h43b0
`define IX_CAL_AMB_B      15'h43b1
`define IX_CAL_AMB_C      15'h43b2
`define IX_CAL_AMB_N      15'h43b3
`define IX_TEMP_GAIN_A    15'h43b4
`define IX_TEMP_GAIN_B    15'h43b5
`define IX_TEMP_GAIN_C    15'h43b6
`define IX_TEMP_GAIN_N    15'h43b7
`define IX_RSV1_LO        15'h43b8
`define IX_RSV1_HI        15'h43bf
`define IX_IRMS_A         15'h43c0
`define IX_VRMS_A         15'h43c1
`define IX_V2RMS_A        15'h43c2
`define IX_IRMS_B         15'h43c3
`define IX_VRMS_B         15'h43c4
`define IX_V2RMS_B        15'h43c5
`define IX_IRMS_C         15'h43c6
`define IX_VRMS_C         15'h43c7
`define IX_V2RMS_C        15'h43c8
`define IX_IRMS_N         15'h43c9
`define IX_CUR_SUM        15'h43ca
`define IX_SENS_TEMP_A    15'h43cb
`define IX_SENS_TEMP_B    15'h43cc
`define IX_SENS_TEMP_C    15'h43cd
`define IX_SENS_TEMP_N    15'h43ce
`define IX_RSV2_LO        15'h43cf
`define IX_RSV2_HI        15'h43ff
// field positions and values
`define IX_LSB            2
`define IX_MSB            16
`define CAL_RESET         24'h000000
`define RESERVED_WORD     32'h00000000
`endif

// ===== design/rms_bank_pkg.sv
package rms_bank_pkg;

  // apb request from the master
  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // calibration words handed to the measurement path
  typedef struct packed {
    logic [23:0] phase_a_fund_current_rms_offset;
    logic [23:0] phase_b_fund_current_rms_offset;
    logic [23:0] phase_c_fund_current_rms_offset;
    logic [23:0] phase_a_fund_voltage_rms_offset;
    logic [23:0] phase_b_fund_voltage_rms_offset;
    logic [23:0] phase_c_fund_voltage_rms_offset;
    logic [23:0] shunt_temp_coefficient;
    logic [23:0] phase_a_cal_ambient_temp;
    logic [23:0] phase_b_cal_ambient_temp;
    logic [23:0] phase_c_cal_ambient_temp;
    logic [23:0] neutral_cal_ambient_temp;
    logic [23:0] phase_a_temp_gain_adjust;
    logic [23:0] phase_b_temp_gain_adjust;
    logic [23:0] phase_c_temp_gain_adjust;
    logic [23:0] neutral_temp_gain_adjust;
  } cal_bank_t;

  // live values from the measurement path
  typedef struct packed {
    logic [23:0] phase_a_current_rms_result;
    logic [23:0] phase_a_voltage_rms_result;
    logic [23:0] phase_a_second_voltage_rms_result;
    logic [23:0] phase_b_current_rms_result;
    logic [23:0] phase_b_voltage_rms_result;
    logic [23:0] phase_b_second_voltage_rms_result;
    logic [23:0] phase_c_current_rms_result;
    logic [23:0] phase_c_voltage_rms_result;
    logic [23:0] phase_c_second_voltage_rms_result;
    logic [23:0] neutral_current_rms_result;
    logic [23:0] phase_a_instant_current;
    logic [23:0] phase_b_instant_current;
    logic [23:0] phase_c_instant_current;
    logic [23:0] phase_a_sensor_temperature;
    logic [23:0] phase_b_sensor_temperature;
    logic [23:0] phase_c_sensor_temperature;
    logic [23:0] neutral_sensor_temperature;
  } meas_in_t;

endpackage : rms_bank_pkg
